// ### common/comm_fault_consts.svh
// Register map, field positions, reset values and timing figures of the command source block
`ifndef COMM_FAULT_CONSTS_SVH
`define COMM_FAULT_CONSTS_SVH

`define ADDR_W 12
`define DATA_W 16

`define REG_SPEED_SRC 12'h18D
`define REG_RUN_SRC 12'h18E
`define REG_SCOPE 12'h190
`define REG_REACTION 12'h191
`define REG_STOP_METHOD 12'h192
`define REG_CONTROL 12'h193
`define REG_STATUS 12'h194
`define REG_IRQ_STATUS 12'h195
`define REG_IRQ_MASK 12'h196

`define CTRL_ENTER_BIT 0
`define CTRL_FAULT_RST_BIT 1

`define IRQ_W 3
`define IRQ_FAULT_BIT 0
`define IRQ_ARMED_BIT 1
`define IRQ_STORED_BIT 2

`define ST_FAULT_BIT 0
`define ST_ALARM_BIT 1
`define ST_CONTACT_BIT 2
`define ST_BOARD_BIT 3
`define ST_ARMED_BIT 4
`define ST_LINK_BIT 5
`define ST_GLOBAL_BIT 6
`define ST_NODE_LSB 8

`define RUN_SRC_RST 3'h0
`define REF_SRC_RST 3'h0
`define SCOPE_RST 1'h0
`define REACTION_RST 3'h0
`define STOP_METHOD_RST 2'h0
`define RUN_SRC_MAX 3'h3
`define REF_SRC_MAX 3'h4
`define REACTION_MAX 3'h4

`define CLK_HZ 25000000
`define BLINK_HALF_MS 100
`define TOKEN_TIMEOUT_MS 50
`define BLINK_HALF_CYC (`CLK_HZ / 1000 * `BLINK_HALF_MS)
`define TOKEN_TIMEOUT_CYC (`CLK_HZ / 1000 * `TOKEN_TIMEOUT_MS)

`endif

// ### common/comm_fault_pkg.sv
// Types shared by the command source and fault supervision block
package comm_fault_pkg;
  typedef enum logic [2:0] {
    SRC_PANEL = 3'h0,
    SRC_TERMINAL = 3'h1,
    SRC_SERIAL = 3'h2,
    SRC_FIELDBUS = 3'h3,
    SRC_PULSE = 3'h4
  } cmd_src_t;

  typedef enum logic [2:0] {
    REACT_RAMP = 3'h0,
    REACT_COAST = 3'h1,
    REACT_FAST = 3'h2,
    REACT_METHOD = 3'h3,
    REACT_ALARM = 3'h4
  } reaction_t;

  typedef enum logic [1:0] {
    STOP_NONE = 2'h0,
    STOP_RAMP = 2'h1,
    STOP_COAST = 2'h2,
    STOP_FAST = 2'h3
  } stop_mode_t;

  typedef struct packed {
    logic run;
    logic reverse;
  } run_cmd_t;

  typedef struct packed {
    logic global_read_en;
    logic cable_loss_en;
    logic [5:0] node_addr;
  } cfg_switch_t;
endpackage : comm_fault_pkg

// ### dv/comm_source_select_fault_reaction_tb.sv
// Self-checking bench for the command source and fault supervision block
`timescale 1ns/100ps
`default_nettype none
`include "comm_fault_consts.svh"
module comm_source_select_fault_reaction_tb
  import comm_fault_pkg::*;
;
  logic sys_clk, rst_n, wr_s, rd_s, nv_load, panel_stop, motor_run, pass_en, send, drop, board;
  logic [11:0] addr;
  logic [15:0] wdata, rdata, q, speed_ref;
  logic [7:0] sw;
  logic [2:0] nv_run, nv_ref, nvr_o, nvf_o;
  run_cmd_t [3:0] run_cmd;
  logic [4:0][15:0] refs;
  run_cmd_t run_o;
  stop_mode_t stop_mode;
  logic nv_store, tok, cmd, lost, ready, ctrl_en, fault, alarm, contact, led, irq, glob;
  logic [5:0] node;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] pat = 8'hB7;
  stop_mode_t exp_sm [5] = '{STOP_RAMP, STOP_COAST, STOP_FAST, STOP_FAST, STOP_NONE};

  comm_source_select_fault_reaction #(.BLINK_HALF_CYC(4), .TOKEN_TIMEOUT_CYC(20))
    i_comm_source_select_fault_reaction (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .config_switch_bank_i(sw),
    .board_present_i(board), .nv_load_i(nv_load), .nv_run_src_i(nv_run),
    .nv_ref_src_i(nv_ref), .nv_store_o(nv_store), .nv_run_src_o(nvr_o),
    .nv_ref_src_o(nvf_o), .run_cmd_i(run_cmd), .speed_ref_i(refs),
    .panel_stop_i(panel_stop), .token_pass_i(tok), .cmd_addressed_i(cmd),
    .master_lost_i(lost), .motor_running_i(motor_run), .run_cmd_o(run_o),
    .speed_ref_o(speed_ref), .fieldbus_ready_o(ready), .fieldbus_ctrl_en_o(ctrl_en),
    .node_addr_o(node), .global_read_en_o(glob), .external_comm_fault_o(fault),
    .alarm_o(alarm), .fault_contact_o(contact), .stop_mode_o(stop_mode),
    .link_status_led_o(led), .irq_o(irq));

  plc_node_model i_plc_node_model (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .pass_en_i(pass_en), .send_i(send),
    .drop_i(drop), .token_pass_o(tok), .cmd_addressed_o(cmd), .master_lost_o(lost));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cy

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 q = rdata;
  endtask : rd

  task automatic wl(input logic v);
    for (int i = 0; i < 12 && led !== v; i++) cy(1);
    chk("led", 16'(v), 16'(led));
  endtask : wl

  initial begin
    {wr_s, rd_s, nv_load, panel_stop, motor_run, pass_en, send, drop} = '0;
    addr = '0;
    wdata = '0;
    sw = 8'hC5;
    board = 1'b1;
    nv_run = 3'h2;
    nv_ref = 3'h1;
    run_cmd = pat;
    for (int k = 0; k < 5; k++) refs[k] = 16'h1000 + 16'(k);
    rst_n = 1'b0;
    cy(12);
    rst_n <= 1'b1;
    cy(6);
    rd(`REG_RUN_SRC); chk("run_src", 16'h0, q);
    rd(`REG_SPEED_SRC); chk("ref_src", 16'h0, q);
    rd(12'h000); chk("unmapped", 16'h0, q);
    chk("ready", 16'h1, 16'(ready));
    rd(`REG_STATUS); chk("status", 16'h0548, q);
    sw <= 8'h3A;
    cy(4);
    rd(`REG_STATUS); chk("status_held", 16'h0548, q);
    chk("node", 16'h5, 16'(node));
    chk("global", 16'h1, 16'(glob));
    $display("test power_up finished");
    for (int s = 0; s < 4; s++) begin
      wr(`REG_RUN_SRC, 16'(s));
      cy(2);
      chk("run_cmd", 16'(pat[2*s+:2]), 16'(run_o));
    end
    wr(`REG_RUN_SRC, 16'h0004);
    rd(`REG_RUN_SRC); chk("run_src_refused", 16'h3, q);
    panel_stop <= 1'b1;
    cy(2);
    chk("panel_stop", 16'h0, 16'(run_o.run));
    panel_stop <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      wr(`REG_SPEED_SRC, 16'(k));
      cy(2);
      chk("speed_ref", refs[k], speed_ref);
    end
    wr(`REG_CONTROL, 16'h0001);
    chk("nv_store", 16'h1, 16'(nv_store));
    chk("nv_run", 16'h3, 16'(nvr_o));
    chk("nv_ref", 16'h4, 16'(nvf_o));
    cy(1);
    chk("nv_store_end", 16'h0, 16'(nv_store));
    nv_load <= 1'b1;
    cy(1);
    nv_load <= 1'b0;
    cy(1);
    rd(`REG_RUN_SRC); chk("nv_run_load", 16'h2, q);
    rd(`REG_SPEED_SRC); chk("nv_ref_load", 16'h1, q);
    wr(`REG_RUN_SRC, 16'h0003);
    $display("test sources finished");
    pass_en <= 1'b1;
    wl(1'b1);
    wl(1'b0);
    wl(1'b1);
    rd(`REG_STATUS); chk("token_active", 16'h1, 16'(q[5]));
    pass_en <= 1'b0;
    cy(30);
    for (int i = 0; i < 8; i++) begin
      cy(1);
      chk("led_dark", 16'h0, 16'(led));
    end
    $display("test led finished");
    wr(`REG_IRQ_MASK, 16'h0001);
    wr(`REG_STOP_METHOD, 16'h0002);
    drop <= 1'b1;
    cy(4);
    chk("fault_unarmed", 16'h0, 16'(fault));
    drop <= 1'b0;
    send <= 1'b1;
    cy(1);
    send <= 1'b0;
    cy(3);
    rd(`REG_STATUS); chk("armed", 16'h1, 16'(q[4]));
    rd(`REG_IRQ_STATUS); chk("irq_status", 16'h6, q);
    for (int r = 0; r < 5; r++) begin
      wr(`REG_REACTION, 16'(r));
      drop <= 1'b1;
      cy(4);
      chk("fault", 16'h1, 16'(fault));
      chk("ctrl_en", 16'h0, 16'(ctrl_en));
      chk("contact", 16'(r < 4), 16'(contact));
      chk("alarm", 16'(r == 4), 16'(alarm));
      chk("stop_mode", 16'(exp_sm[r]), 16'(stop_mode));
      chk("run", 16'(r == 4), 16'(run_o.run));
      chk("irq", 16'h1, 16'(irq));
      drop <= 1'b0;
      cy(4);
      chk("fault_held", 16'h1, 16'(fault));
      chk("contact_held", 16'(r < 4), 16'(contact));
      wr(`REG_CONTROL, 16'h0002);
      wr(`REG_IRQ_STATUS, 16'h0001);
      cy(2);
      chk("fault_reset", 16'h0, 16'(fault));
      chk("irq_clear", 16'h0, 16'(irq));
      chk("ctrl_back", 16'h1, 16'(ctrl_en));
    end
    $display("test reactions finished");
    wr(`REG_SCOPE, 16'h0001);
    wr(`REG_REACTION, 16'h0000);
    drop <= 1'b1;
    cy(4);
    chk("fault_idle", 16'h0, 16'(fault));
    motor_run <= 1'b1;
    cy(4);
    chk("fault_run", 16'h1, 16'(fault));
    drop <= 1'b0;
    cy(2);
    wr(`REG_CONTROL, 16'h0002);
    wr(`REG_REACTION, 16'h0004);
    drop <= 1'b1;
    cy(4);
    chk("fault_suppressed", 16'h0, 16'(fault));
    {drop, motor_run} <= 2'h0;
    $display("test scope finished");
    // Second power-up without the option board; switches were changed meanwhile
    board <= 1'b0;
    rst_n <= 1'b0;
    cy(2);
    rst_n <= 1'b1;
    cy(6);
    chk("ready_absent", 16'h0, 16'(ready));
    chk("ctrl_absent", 16'h0, 16'(ctrl_en));
    chk("node_recapture", 16'h3A, 16'(node));
    wr(`REG_RUN_SRC, 16'h0003);
    cy(2);
    chk("run_absent", 16'h0, 16'(run_o));
    $display("test no_board finished");
    end_sim();
  end
endmodule : comm_source_select_fault_reaction_tb
`default_nettype wire

// ### dv/plc_node_model.sv
// Behavioural remote controller node that passes the token and addresses this drive
`timescale 1ns/100ps
`default_nettype none
module plc_node_model (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic pass_en_i, // Keep the token rotating
  input wire logic send_i, // Send one command to this node
  input wire logic drop_i, // Master leaves the rotation
  output logic token_pass_o, // Token passed pulse
  output logic cmd_addressed_o, // Non-global command pulse
  output logic master_lost_o // Master gone, level
);
  logic [1:0] cnt_q;
  // Single segment, so no bridge routing path is carried
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      token_pass_o <= 1'b0;
      cmd_addressed_o <= 1'b0;
      master_lost_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      token_pass_o <= pass_en_i && (cnt_q == 2'h0);
      cmd_addressed_o <= send_i; // Sent to this node's unique address only
      master_lost_o <= drop_i;
    end
  end
endmodule : plc_node_model
`default_nettype wire

// ### src/comm_source_select_fault_reaction.sv
// Command source selection and communication fault supervision
`timescale 1ns/100ps
`default_nettype none
`include "comm_fault_consts.svh"

// Functional notes
// - Run/stop comes from panel, terminals, serial or fieldbus per run source select.
// - Speed reference from panel, terminals, serial, fieldbus or pulse input per selector.
// - Enter command stores both source selectors to non-volatile memory.
// - Some commands, such as panel stop, act whatever source is selected.
// - At power-up detect the option board and prepare fieldbus operation.
// - Status LED blinks rapidly while the node passes the token.
// - On comm fault, ignore fieldbus control, raise fault, then react per settings.
// - Detection scope 0 detects always; 1 only while the motor runs.
// - Reaction 0: show fault, close contact, ramp to stop.
// - Reaction 1: show fault, close contact, let motor coast.
// - Reaction 2: show fault, close contact, fast stop.
// - Reaction 3: show fault, close contact, stop by stop method select.
// - Reaction 4: alarm only, contact open, keep running in last state.
// - Configuration switches are read at power-up only.
// - Cable-loss detection arms after first non-global command to this node.
// - Alarm-only with during-run scope suppresses cable-loss fault.
module comm_source_select_fault_reaction
  import comm_fault_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
  parameter int unsigned TOKEN_TIMEOUT_CYC = `TOKEN_TIMEOUT_CYC
) (
  input wire logic sys_clk_i, // System clock, 25 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [`ADDR_W-1:0] reg_addr_i, // Register address
  input wire logic [`DATA_W-1:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [`DATA_W-1:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic [7:0] config_switch_bank_i, // Switch pins
  input wire logic board_present_i, // Option board fitted pin
  input wire logic nv_load_i, // Restore pulse from non-volatile store
  input wire logic [2:0] nv_run_src_i, // Restored run source
  input wire logic [2:0] nv_ref_src_i, // Restored reference source
  output logic nv_store_o, // Store pulse
  output logic [2:0] nv_run_src_o, // Run source to store
  output logic [2:0] nv_ref_src_o, // Reference source to store
  input wire run_cmd_t [3:0] run_cmd_i, // Run commands by source
  input wire logic [4:0][15:0] speed_ref_i, // Speed references by source
  input wire logic panel_stop_i, // Panel stop key
  input wire logic token_pass_i, // Token passed pulse
  input wire logic cmd_addressed_i, // Non-global command to this node
  input wire logic master_lost_i, // Master dropped from rotation
  input wire logic motor_running_i, // Motor running
  output run_cmd_t run_cmd_o, // Selected run command
  output logic [15:0] speed_ref_o, // Selected speed reference
  output logic fieldbus_ready_o, // Board initialised for fieldbus
  output logic fieldbus_ctrl_en_o, // Fieldbus control accepted
  output logic [5:0] node_addr_o, // Captured node address
  output logic global_read_en_o, // Captured global read enable
  output logic external_comm_fault_o, // Fault code displayed
  output logic alarm_o, // Alarm-only indication
  output logic fault_contact_o, // Fault contact closed
  output stop_mode_t stop_mode_o, // Stop method applied
  output logic link_status_led_o, // Green link LED
  output logic irq_o // Interrupt, level
);
  typedef enum logic [1:0] {
    ST_WAIT0 = 2'b00,
    ST_WAIT1 = 2'b01,
    ST_CAPTURE = 2'b10,
    ST_READY = 2'b11
  } init_state_t;

  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] r);
    return a == r;
  endfunction : hit

  function automatic stop_mode_t method_mode(input logic [1:0] m);
    unique case (m)
      2'h1: return STOP_COAST;
      2'h2: return STOP_FAST;
      default: return STOP_RAMP;
    endcase
  endfunction : method_mode

  // Pin synchronisers
  logic [7:0] sw_meta_q, sw_sync_q;
  logic board_meta_q, board_sync_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_meta_q <= 8'h00;
      sw_sync_q <= 8'h00;
      board_meta_q <= 1'b0;
      board_sync_q <= 1'b0;
    end else begin
      sw_meta_q <= config_switch_bank_i;
      sw_sync_q <= sw_meta_q;
      board_meta_q <= board_present_i;
      board_sync_q <= board_meta_q;
    end
  end

  // Power-up capture
  init_state_t init_q, init_d;
  cfg_switch_t cfg_q, cfg_d;
  logic board_q, board_d;

  always_comb begin
    init_d = init_q;
    cfg_d = cfg_q;
    board_d = board_q;
    unique case (init_q)
      ST_WAIT0: init_d = ST_WAIT1;
      ST_WAIT1: init_d = ST_CAPTURE;
      ST_CAPTURE: begin
        cfg_d = sw_sync_q;
        board_d = board_sync_q;
        init_d = ST_READY;
      end
      ST_READY: init_d = ST_READY; // Later switch changes are ignored
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_q <= ST_WAIT0;
      cfg_q <= 8'h00;
      board_q <= 1'b0;
    end else begin
      init_q <= init_d;
      cfg_q <= cfg_d;
      board_q <= board_d;
    end
  end

  logic ready;
  assign ready = (init_q == ST_READY) && board_q;

  // Register file
  logic [2:0] run_src_q, run_src_d, ref_src_q, ref_src_d;
  logic scope_q, scope_d;
  logic [2:0] react_set_q, react_set_d;
  logic [1:0] method_q, method_d;
  logic [`IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, irq_set;
  logic [`DATA_W-1:0] rdata_q, rdata_d, status;
  logic nv_store_q, nv_store_d;
  logic [2:0] nv_run_q, nv_run_d, nv_ref_q, nv_ref_d;
  logic fault_rst;
  logic fault_q, armed_q, link_active;
  logic [2:0] react_q;

  assign fault_rst = reg_wr_i && hit(reg_addr_i, `REG_CONTROL) &&
                     reg_wdata_i[`CTRL_FAULT_RST_BIT];

  always_comb begin
    status = '0;
    status[`ST_FAULT_BIT] = fault_q;
    status[`ST_ALARM_BIT] = alarm_o;
    status[`ST_CONTACT_BIT] = fault_contact_o;
    status[`ST_BOARD_BIT] = ready;
    status[`ST_ARMED_BIT] = armed_q;
    status[`ST_LINK_BIT] = link_active;
    status[`ST_GLOBAL_BIT] = cfg_q.global_read_en;
    status[`ST_NODE_LSB +: 6] = cfg_q.node_addr;
  end

  always_comb begin
    run_src_d = run_src_q;
    ref_src_d = ref_src_q;
    scope_d = scope_q;
    react_set_d = react_set_q;
    method_d = method_q;
    irq_mask_d = irq_mask_q;
    nv_store_d = 1'b0;
    nv_run_d = nv_run_q;
    nv_ref_d = nv_ref_q;
    rdata_d = '0;
    if (nv_load_i) begin
      if (nv_run_src_i <= `RUN_SRC_MAX) run_src_d = nv_run_src_i;
      if (nv_ref_src_i <= `REF_SRC_MAX) ref_src_d = nv_ref_src_i;
    end
    // Out-of-range selector values are refused and the old setting kept
    if (reg_wr_i) begin
      if (hit(reg_addr_i, `REG_RUN_SRC) && reg_wdata_i <= 16'(`RUN_SRC_MAX))
        run_src_d = reg_wdata_i[2:0];
      if (hit(reg_addr_i, `REG_SPEED_SRC) && reg_wdata_i <= 16'(`REF_SRC_MAX))
        ref_src_d = reg_wdata_i[2:0];
      if (hit(reg_addr_i, `REG_SCOPE) && reg_wdata_i <= 16'h0001)
        scope_d = reg_wdata_i[0];
      if (hit(reg_addr_i, `REG_REACTION) && reg_wdata_i <= 16'(`REACTION_MAX))
        react_set_d = reg_wdata_i[2:0];
      if (hit(reg_addr_i, `REG_STOP_METHOD) && reg_wdata_i <= 16'h0003)
        method_d = reg_wdata_i[1:0];
      if (hit(reg_addr_i, `REG_IRQ_MASK))
        irq_mask_d = reg_wdata_i[`IRQ_W-1:0];
      if (hit(reg_addr_i, `REG_CONTROL) && reg_wdata_i[`CTRL_ENTER_BIT]) begin
        nv_store_d = 1'b1;
        nv_run_d = run_src_q;
        nv_ref_d = ref_src_q;
      end
    end
    if (reg_rd_i) begin
      unique case (1'b1)
        hit(reg_addr_i, `REG_RUN_SRC): rdata_d = {13'h0000, run_src_q};
        hit(reg_addr_i, `REG_SPEED_SRC): rdata_d = {13'h0000, ref_src_q};
        hit(reg_addr_i, `REG_SCOPE): rdata_d = {15'h0000, scope_q};
        hit(reg_addr_i, `REG_REACTION): rdata_d = {13'h0000, react_set_q};
        hit(reg_addr_i, `REG_STOP_METHOD): rdata_d = {14'h0000, method_q};
        hit(reg_addr_i, `REG_STATUS): rdata_d = status;
        hit(reg_addr_i, `REG_IRQ_STATUS): rdata_d = {13'h0000, irq_st_q};
        hit(reg_addr_i, `REG_IRQ_MASK): rdata_d = {13'h0000, irq_mask_q};
        default: rdata_d = '0;
      endcase
    end
    // Write-one-to-clear; a new event in the same cycle wins
    irq_st_d = irq_st_q;
    if (reg_wr_i && hit(reg_addr_i, `REG_IRQ_STATUS))
      irq_st_d = irq_st_q & ~reg_wdata_i[`IRQ_W-1:0];
    irq_st_d = irq_st_d | irq_set;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_src_q <= `RUN_SRC_RST;
      ref_src_q <= `REF_SRC_RST;
      scope_q <= `SCOPE_RST;
      react_set_q <= `REACTION_RST;
      method_q <= `STOP_METHOD_RST;
      irq_st_q <= '0;
      irq_mask_q <= '0;
      nv_store_q <= 1'b0;
      nv_run_q <= 3'h0;
      nv_ref_q <= 3'h0;
      rdata_q <= '0;
    end else begin
      run_src_q <= run_src_d;
      ref_src_q <= ref_src_d;
      scope_q <= scope_d;
      react_set_q <= react_set_d;
      method_q <= method_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      nv_store_q <= nv_store_d;
      nv_run_q <= nv_run_d;
      nv_ref_q <= nv_ref_d;
      rdata_q <= rdata_d;
    end
  end

  // Fault supervision
  logic fault_d, armed_d, suppress, detect;
  logic [2:0] react_d;

  assign suppress = (react_set_q == REACT_ALARM) && scope_q;
  assign detect = ready && armed_q && master_lost_i && !suppress &&
                  (!scope_q || motor_running_i);

  always_comb begin
    armed_d = armed_q;
    fault_d = fault_q;
    react_d = react_q;
    if (ready && cfg_q.cable_loss_en && cmd_addressed_i) armed_d = 1'b1;
    if (fault_rst) fault_d = 1'b0;
    // The reaction is frozen when the fault is raised
    if (detect) begin
      fault_d = 1'b1;
      if (!fault_q) react_d = react_set_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b0;
      fault_q <= 1'b0;
      react_q <= `REACTION_RST;
    end else begin
      armed_q <= armed_d;
      fault_q <= fault_d;
      react_q <= react_d;
    end
  end

  logic halt;
  assign halt = fault_q && (react_q != REACT_ALARM);
  assign irq_set = {nv_store_q, armed_d && !armed_q, detect && !fault_q};

  // Command selection
  run_cmd_t run_q, run_d;
  logic [15:0] ref_q, ref_d;
  logic fb_ok;

  assign fb_ok = ready && !fault_q;

  always_comb begin
    run_d = run_cmd_i[run_src_q[1:0]];
    ref_d = speed_ref_i[ref_src_q];
    // Blocked fieldbus keeps the last state; an absent board gives no command
    if (run_src_q == SRC_FIELDBUS && !fb_ok) run_d = ready ? run_q : 2'b00;
    if (ref_src_q == SRC_FIELDBUS && !fb_ok) ref_d = ready ? ref_q : 16'h0000;
    if (halt) run_d.run = 1'b0;
    if (panel_stop_i) run_d.run = 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 2'b00;
      ref_q <= 16'h0000;
    end else begin
      run_q <= run_d;
      ref_q <= ref_d;
    end
  end

  always_comb begin
    stop_mode_o = STOP_NONE;
    if (halt) begin
      unique case (react_q)
        REACT_COAST: stop_mode_o = STOP_COAST;
        REACT_FAST: stop_mode_o = STOP_FAST;
        REACT_METHOD: stop_mode_o = method_mode(method_q);
        default: stop_mode_o = STOP_RAMP;
      endcase
    end
  end

  link_led_blinker #(
    .HALF_CYC(BLINK_HALF_CYC),
    .TIMEOUT_CYC(TOKEN_TIMEOUT_CYC)
  ) u_led (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ready_i(ready),
    .token_i(token_pass_i),
    .active_o(link_active),
    .led_o(link_status_led_o)
  );

  assign reg_rdata_o = rdata_q;
  assign nv_store_o = nv_store_q;
  assign nv_run_src_o = nv_run_q;
  assign nv_ref_src_o = nv_ref_q;
  assign run_cmd_o = run_q;
  assign speed_ref_o = ref_q;
  assign fieldbus_ready_o = ready;
  assign fieldbus_ctrl_en_o = fb_ok;
  assign node_addr_o = cfg_q.node_addr;
  assign global_read_en_o = cfg_q.global_read_en;
  assign external_comm_fault_o = fault_q;
  assign alarm_o = fault_q && (react_q == REACT_ALARM);
  assign fault_contact_o = halt;
  assign irq_o = |(irq_st_q & irq_mask_q);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  run_select_a: assert property (
    run_src_q == SRC_TERMINAL && !panel_stop_i && !halt |=> run_cmd_o == $past(run_cmd_i[1]))
    else $error("run command not taken from terminals");
  ref_select_a: assert property (
    ref_src_q == SRC_PULSE |=> speed_ref_o == $past(speed_ref_i[4]))
    else $error("speed reference not taken from pulse input");
  enter_store_a: assert property (
    reg_wr_i && hit(reg_addr_i, `REG_CONTROL) && reg_wdata_i[0]
    |=> nv_store_o && nv_run_src_o == $past(run_src_q) ##1 !nv_store_o)
    else $error("enter did not store selectors");
  panel_stop_a: assert property (panel_stop_i |=> !run_cmd_o.run)
    else $error("panel stop ignored");
  board_init_a: assert property (
    init_q == ST_CAPTURE |=> fieldbus_ready_o == $past(board_sync_q))
    else $error("board presence not captured");
  fault_raise_a: assert property (
    detect |=> external_comm_fault_o && !fieldbus_ctrl_en_o)
    else $error("comm fault not raised");
  scope_run_a: assert property (
    scope_q && !motor_running_i && !fault_q |=> !fault_q)
    else $error("fault detected while stopped in run scope");
  ramp_stop_a: assert property (
    fault_q && react_q == REACT_RAMP |-> fault_contact_o && stop_mode_o == STOP_RAMP)
    else $error("ramp reaction wrong");
  coast_stop_a: assert property (
    fault_q && react_q == REACT_COAST |-> fault_contact_o && stop_mode_o == STOP_COAST)
    else $error("coast reaction wrong");
  fast_stop_a: assert property (
    fault_q && react_q == REACT_FAST |-> fault_contact_o && stop_mode_o == STOP_FAST)
    else $error("fast stop reaction wrong");
  method_stop_a: assert property (
    fault_q && react_q == REACT_METHOD |-> fault_contact_o && stop_mode_o ==
      (method_q == 2'h2 ? STOP_FAST : (method_q == 2'h1 ? STOP_COAST : STOP_RAMP)))
    else $error("stop method not applied");
  alarm_only_a: assert property (
    alarm_o |-> !fault_contact_o && stop_mode_o == STOP_NONE)
    else $error("alarm-only closed contact or stopped");
  switch_hold_a: assert property (init_q == ST_READY |=> $stable(cfg_q))
    else $error("switches resampled after power-up");
  arm_wait_a: assert property (!armed_q && !fault_q |=> !fault_q)
    else $error("fault before detection armed");
  suppress_a: assert property (suppress && !fault_q |=> !fault_q)
    else $error("suppressed fault raised");
  fault_hold_a: assert property (fault_q && !fault_rst |=> fault_q)
    else $error("fault dropped without reset");
endmodule : comm_source_select_fault_reaction
`default_nettype wire

// ### src/link_led_blinker.sv
// Token activity watchdog and rapid blink generator for the link status LED
`timescale 1ns/100ps
`default_nettype none
module link_led_blinker #(
  parameter int unsigned HALF_CYC = 2500000,
  parameter int unsigned TIMEOUT_CYC = 1250000
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic ready_i, // Board initialised
  input wire logic token_i, // Token passed, one-cycle pulse
  output logic active_o, // Token seen recently
  output logic led_o // LED drive
);
  localparam int unsigned HW = $clog2(HALF_CYC + 1);
  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

  logic [HW-1:0] div_q, div_d;
  logic [TW-1:0] tmo_q, tmo_d;
  logic led_q, led_d;

  always_comb begin
    tmo_d = tmo_q;
    div_d = div_q;
    led_d = led_q;
    if (!ready_i) begin
      tmo_d = '0;
    end else if (token_i) begin
      tmo_d = TW'(TIMEOUT_CYC);
    end else if (tmo_q != '0) begin
      tmo_d = tmo_q - TW'(1);
    end
    // LED stays dark unless the node keeps passing the token
    if (tmo_q == '0) begin
      div_d = '0;
      led_d = 1'b0;
    end else if (div_q == HW'(HALF_CYC - 1)) begin
      div_d = '0;
      led_d = ~led_q;
    end else begin
      div_d = div_q + HW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_q <= '0;
      div_q <= '0;
      led_q <= 1'b0;
    end else begin
      tmo_q <= tmo_d;
      div_q <= div_d;
      led_q <= led_d;
    end
  end

  assign active_o = (tmo_q != '0);
  assign led_o = led_q;

  led_dark_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !active_o |=> !led_o)
    else $error("link LED lit without token activity");
endmodule : link_led_blinker
`default_nettype wire
